// >>> verilog/config_handshake_sequencer.sv
// Purpose: power-on delay and restart/status handshake for config loading
// Assumes: mclk 50 MHz; loader_ref_clock checked by the host side
// Notes: loader datapath is outside; it reports finished/error here
//        secure mode is not told apart: status falls in cycles, so
//        the shorter restart limit is met in every mode
//        error pulse is fixed at the 0.5 ms floor; init at 2.5 ms
//        counts are parameters so a bench can shrink them
`timescale 1ns/1ps
module config_handshake_sequencer
    import cfg_seq_pkg::*;
#(
    parameter int unsigned por_normal_cycles = por_normal_cyc,
    parameter int unsigned por_fast_cycles = por_fast_cyc,
    parameter int unsigned err_pulse_cycles = err_pulse_cyc,
    parameter int unsigned init_cycles = init_cyc
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic restart_request_low,
    input wire logic supplies_ok,
    input wire logic fast_flash_mode,
    input wire logic load_finished,
    input wire logic load_error,
    output logic device_state_low,
    output logic load_complete,
    output logic startup_complete,
    output logic load_enable
);
    // compare limits sit one below the wanted count, so the state
    // changes on the edge that completes that many cycles
    localparam logic [cnt_w-1:0] por_n = cnt_w'(por_normal_cycles - 1);
    localparam logic [cnt_w-1:0] por_f = cnt_w'(por_fast_cycles - 1);
    localparam logic [cnt_w-1:0] err_n = cnt_w'(err_pulse_cycles - 1);
    localparam logic [cnt_w-1:0] init_n = cnt_w'(init_cycles - 1);

    // every flop of the block lives in this one struct
    seq_regs_t r;
    seq_regs_t next_r;

    // pin views after the two-stage synchronisers
    logic req_high;
    logic sup_up;

    // counter helpers, all decoded from the registered count; the
    // counter width holds the longest default delay with room to spare
    logic count_full;
    logic [cnt_w-1:0] count_step;
    logic por_done;
    logic err_done;
    logic init_done;

    // only the second stage is read; the first may still be settling
    // req_high means the host is not asking for a restart
    assign req_high = r.req_sync[1];
    assign sup_up = r.sup_sync[1];

    // the counter stops at all ones instead of wrapping, yet a reload
    // to zero on a state change still wins: a long stay in held or user
    // mode cannot cut a later error pulse or init window short
    assign count_full = (r.count == '1);
    assign count_step = count_full ? r.count : r.count + cnt_w'(1);

    // boot mode is read live: a change during the delay simply picks
    // the other limit, so the strap must be steady before supplies rise
    assign por_done = fast_flash_mode ? (r.count >= por_f)
                                      : (r.count >= por_n);
    assign err_done = (r.count >= err_n);
    assign init_done = (r.count >= init_n);

    // state walk:
    //   por   - supplies seen, counting the power-on delay
    //   held  - status low, waiting for the restart line to go high
    //   load  - status high, loader fetching data
    //   error - status low for the fixed error pulse
    //   init  - data loaded, counting the initialisation time
    //   user  - configuration done, waiting for a restart
    // a restart drop in load, init or user goes back to held; held and
    // error ignore it, por ignores it until the delay is over
    // an illegal state code goes back to por
    always_comb begin
        next_r = r;
        // synchronisers shift every cycle, whatever the state
        next_r.req_sync = {r.req_sync[0], restart_request_low};
        next_r.sup_sync = {r.sup_sync[0], supplies_ok};
        next_r.count = count_step;

        case (r.state)
            st_por: begin
                // delay starts only once supplies are up; a supply dip
                // while counting starts it again from zero
                if (!sup_up) begin
                    next_r.count = cnt_reset;
                end else if (por_done) begin
                    next_r.state = st_held;
                    next_r.count = cnt_reset;
                end
            end

            st_held: begin
                // status low, loader stopped, flags clear until the host
                // lets the restart line go high again
                next_r.device_state_low = 1'b1;
                next_r.load_enable = 1'b0;
                next_r.load_complete = 1'b0;
                next_r.startup_complete = 1'b0;
                if (req_high) begin
                    // release within a few cycles, far below 20 ms
                    next_r.state = st_load;
                    next_r.device_state_low = 1'b0;
                    next_r.load_enable = 1'b1;
                end
            end

            st_load: begin
                // a restart drop has priority over anything the loader says
                if (!req_high) begin
                    next_r.state = st_held;
                    next_r.device_state_low = 1'b1;
                    next_r.load_enable = 1'b0;
                end else if (load_error) begin
                    // error beats finished in one cycle: the data is suspect
                    next_r.state = st_error;
                    next_r.count = cnt_reset;
                    next_r.device_state_low = 1'b1;
                    next_r.load_enable = 1'b0;
                end else if (load_finished) begin
                    // loader stops fetching the moment it reports done
                    next_r.state = st_init;
                    next_r.count = cnt_reset;
                    next_r.load_complete = 1'b1;
                    next_r.load_enable = 1'b0;
                end
            end

            st_error: begin
                // fixed 0.5 ms pulse, inside the 10 ms ceiling; the restart
                // line is not looked at until the pulse is over
                if (err_done) begin
                    next_r.state = st_held;
                    next_r.count = cnt_reset;
                end
            end

            st_init: begin
                // init takes half the 5 ms budget, which leaves margin for
                // a slower mclk than planned
                if (!req_high) begin
                    // flags fall together with status on a restart drop
                    next_r.state = st_held;
                    next_r.device_state_low = 1'b1;
                    next_r.load_complete = 1'b0;
                end else if (init_done) begin
                    next_r.state = st_user;
                    next_r.startup_complete = 1'b1;
                end
            end

            st_user: begin
                // restart drop while configured: clean state in a few
                // cycles, far inside 400 ms and the secure-mode allowance
                if (!req_high) begin
                    // flags and status fall together: the host sees one edge
                    next_r.state = st_held;
                    next_r.device_state_low = 1'b1;
                    next_r.load_complete = 1'b0;
                    next_r.startup_complete = 1'b0;
                end
            end

            default: begin
                // an illegal code falls back to a full power-on delay with
                // every pin in its reset state
                next_r.state = st_por;
                next_r.count = cnt_reset;
                next_r.device_state_low = 1'b1;
                next_r.load_complete = 1'b0;
                next_r.startup_complete = 1'b0;
                next_r.load_enable = 1'b0;
            end
        endcase
    end

    // synchronous reset loads constants only; status stays low through
    // reset so the host never sees a false release
    // the synchronisers clear to zero: restart reads as asserted and
    // supplies as absent until the pins have been seen twice
    always_ff @(posedge mclk) begin
        if (reset) begin
            r.state <= st_por;
            r.count <= cnt_reset;
            r.req_sync <= 2'h0;
            r.sup_sync <= 2'h0;
            r.device_state_low <= 1'b1;
            r.load_complete <= 1'b0;
            r.startup_complete <= 1'b0;
            r.load_enable <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // outputs come straight from the state flops, with no logic after
    // them, so the pins cannot glitch between edges
    assign device_state_low = r.device_state_low;
    assign load_complete = r.load_complete;
    assign startup_complete = r.startup_complete;
    assign load_enable = r.load_enable;
endmodule

// >>> verilog/cfg_seq_pkg.sv
// Purpose: constants and types for the configuration handshake sequencer
// Assumes: 50 MHz mclk
// Notes: long counts are also top-level parameters
package cfg_seq_pkg;
    localparam int unsigned clk_mhz = 50;
    // times in microseconds, as printed in ms times 1000
    localparam int unsigned por_normal_min_us = 12000;
    localparam int unsigned por_normal_max_us = 20000;
    localparam int unsigned por_fast_min_us = 2000;
    localparam int unsigned por_fast_max_us = 6500;
    localparam int unsigned release_max_us = 20000;
    localparam int unsigned pull_low_max_us = 400000;
    localparam int unsigned pull_low_secure_max_us = 1000000;
    localparam int unsigned err_pulse_min_us = 500;
    localparam int unsigned err_pulse_max_us = 10000;
    localparam int unsigned user_mode_max_us = 5000;
    // cycle counts: minimum times rounded up
    localparam int unsigned por_normal_cyc = por_normal_min_us * clk_mhz;
    localparam int unsigned por_fast_cyc = por_fast_min_us * clk_mhz;
    localparam int unsigned err_pulse_cyc = err_pulse_min_us * clk_mhz;
    // init time well inside the 5 ms window; maximum rounds down
    localparam int unsigned init_cyc = (user_mode_max_us * clk_mhz) / 2;
    localparam int unsigned cnt_w = 26;
    localparam logic [cnt_w-1:0] cnt_reset = 26'h0;

    typedef enum logic [5:0] {
        st_por     = 6'h01,
        st_held    = 6'h02,
        st_load    = 6'h04,
        st_error   = 6'h08,
        st_init    = 6'h10,
        st_user    = 6'h20
    } seq_state_t;

    typedef struct packed {
        logic restart_request_low;
        logic supplies_ok;
        logic fast_flash_mode;
        logic load_finished;
        logic load_error;
    } seq_in_t;

    typedef struct packed {
        seq_state_t state;
        logic [cnt_w-1:0] count;
        logic [1:0] req_sync;
        logic [1:0] sup_sync;
        logic device_state_low;
        logic load_complete;
        logic startup_complete;
        logic load_enable;
    } seq_regs_t;
endpackage

// >>> dv/cfg_seq_monitor.sv
// Purpose: pin timing checks
// Assumes: error pulse of 8 cycles
// Notes: up saturates, so it never wraps
`timescale 1ns/1ps
module cfg_seq_monitor #(
    parameter int unsigned por_normal_cycles = 20,
    parameter int unsigned por_fast_cycles = 10
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic restart_request_low,
    input wire logic supplies_ok,
    input wire logic fast_flash_mode,
    input wire logic load_finished,
    input wire logic load_error,
    input wire logic device_state_low,
    input wire logic load_complete,
    input wire logic startup_complete,
    input wire logic load_enable
);
    int unsigned up;
    wire logic rdy = up > por_normal_cycles + 4;
    always_ff @(posedge mclk) begin
        if (reset || !supplies_ok)
            up <= 0;
        else if (!rdy)
            up <= up + 1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    por_hold_a: assert property (
        up <= (fast_flash_mode ? por_fast_cycles : por_normal_cycles)
        |-> device_state_low) else $error("early release");
    status_rel_a: assert property (
        $rose(restart_request_low) && rdy |-> ##[1:4] !device_state_low)
        else $error("no release");
    status_pull_a: assert property (
        $fell(restart_request_low) && rdy |-> ##[1:4] device_state_low)
        else $error("no pull low");
    err_pulse_a: assert property (
        $rose(load_error) && load_enable
        |=> (device_state_low && !load_complete)[*8]) else $error("short");
    user_mode_a: assert property (
        $rose(load_complete) |-> !startup_complete[*5] ##[1:2]
        startup_complete) else $error("late user mode");
    load_done_a: assert property (
        load_finished && load_enable |=> load_complete && !load_enable)
        else $error("no load done");
    flags_clear_a: assert property (
        $fell(restart_request_low) && load_complete
        |-> ##[1:4] !load_complete && !startup_complete) else $error("flags");
    held_low_a: assert property (
        !restart_request_low[*4] |-> device_state_low && !load_enable)
        else $error("not held");
endmodule
bind config_handshake_sequencer cfg_seq_monitor #(
    .por_normal_cycles(por_normal_cycles),
    .por_fast_cycles(por_fast_cycles)) mon_i (.*);

// >>> dv/cfg_host_model.sv
// Purpose: host on the restart pin
// Assumes: want is a level
// Notes: no wait after status edges
`timescale 1ns/1ps
module cfg_host_model #(
    parameter int unsigned ref_clock_mhz = 100, // 25, 100 or 125
    parameter int unsigned selected_mhz = 100 // must match applied
) (
    input wire logic mclk,
    input wire logic want,
    output logic restart_request_low,
    output logic ref_ok
);
    initial restart_request_low = 1'b0;
    always @(posedge mclk) restart_request_low <= #1 !want;
    // the host owns the reference clock; flag a setting it may not use
    assign ref_ok = (ref_clock_mhz == 25 || ref_clock_mhz == 100 ||
        ref_clock_mhz == 125) && ref_clock_mhz == selected_mhz;
endmodule

// >>> dv/config_handshake_sequencer_tb.sv
// Purpose: bench for the sequencer
// Assumes: counts 20/10/8/6
// Notes: rows give power-on delay per boot mode
`timescale 1ns/1ps
module config_handshake_sequencer_tb;
    logic mclk = 0, reset = 1, want = 0, sup = 0, fast = 0, fin = 0, err = 0;
    logic rq, dsl, lc, sc, le, ref_ok;
    int num_errors = 0, n_checks = 0, n;
    int rows [2][3] = '{'{0, 20, 26}, '{1, 10, 16}};
    cfg_host_model cfg_host_model_i (.mclk(mclk), .want(want),
        .restart_request_low(rq), .ref_ok(ref_ok));
    config_handshake_sequencer #(.por_normal_cycles(20),
        .por_fast_cycles(10), .err_pulse_cycles(8), .init_cycles(6))
        config_handshake_sequencer_i (.mclk(mclk), .reset(reset),
        .restart_request_low(rq), .supplies_ok(sup), .fast_flash_mode(fast),
        .load_finished(fin), .load_error(err), .device_state_low(dsl),
        .load_complete(lc), .startup_complete(sc), .load_enable(le));
    initial forever #10 mclk = ~mclk;
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wait_rel();
        for (n = 0; dsl !== 1'b0; n++) begin
            tick(1);
            if (n > 100) begin
                check(n, 0);
                print_verdict();
            end
        end
    endtask
    initial begin
        check(ref_ok, 1);
        foreach (rows[i]) begin
            reset = 1;
            sup = 0;
            fast = rows[i][0][0];
            tick(5);
            check({dsl, lc, sc, le}, 4'h8);
            reset = 0;
            sup = 1;
            wait_rel();
            check(n >= rows[i][1] && n <= rows[i][2], 1);
        end
        check(le, 1);
        fin = 1;
        tick(1);
        fin = 0;
        check({lc, le}, 2'h2);
        tick(5);
        check(sc, 0);
        tick(1);
        check(sc, 1);
        want = 1;
        tick(5);
        check({dsl, lc, sc}, 3'h4);
        fin = 1;
        tick(3);
        check({lc, le}, 2'h0);
        fin = 0;
        want = 0;
        wait_rel();
        check(n < 8, 1);
        err = 1;
        tick(1);
        err = 0;
        check({dsl, le}, 2'h2);
        tick(7);
        check(dsl, 1);
        want = 1;
        tick(2);
        check(dsl, 0);
        want = 0;
        tick(2);
        check({dsl, le}, 2'h2);
        wait_rel();
        check(le, 1);
        print_verdict();
    end
endmodule
